// *** verilog/pfrs_defs.svh ***
// register offsets, field positions, reset values and timing counts of the sequencer
`ifndef PFRS_DEFS_SVH
`define PFRS_DEFS_SVH
`define PFRS_OFF_CTRL 12'h000
`define PFRS_OFF_STATUS 12'h004
`define PFRS_OFF_CYCLE 12'h008
`define PFRS_OFF_LATCH 12'h00C
`define PFRS_OFF_CHART 12'h010
`define PFRS_OFF_OUTS 12'h014
`define PFRS_OFF_SAVED 12'h018
`define PFRS_CTRL_RUN 0
`define PFRS_CTRL_WDG_EN 1
`define PFRS_CTRL_WDG_ERR 2
`define PFRS_CTRL_SAVE_DONE 3
`define PFRS_CTRL_AC_SUPPLY 4
`define PFRS_CTRL_RESET 32'h0000_0000
`define PFRS_CYCLE_MS_RESET 8'h0A
`define PFRS_CLK_MHZ 100
`define PFRS_MS_NS 1000000
`define PFRS_CLK_NS 10
`define PFRS_MS_CYCLES (`PFRS_MS_NS / `PFRS_CLK_NS)
`define PFRS_ANALOG_MS 20
`define PFRS_LINK_HOLD_MS 80
`define PFRS_MAX_DISPLAYS 32
`endif

// *** verilog/pfrs_pkg.sv ***
// types of the power fail restart sequencer
package pfrs_pkg;
  typedef enum logic [6:0] {
    PFRS_ST_RUN = 7'h01,
    PFRS_ST_HOLD = 7'h02,
    PFRS_ST_OFF = 7'h04,
    PFRS_ST_CHECK = 7'h08,
    PFRS_ST_RESTORE = 7'h10,
    PFRS_ST_INIT = 7'h20,
    PFRS_ST_STOP = 7'h40
  } pfrs_state_t;
endpackage

// *** verilog/pfrs_sequencer.sv ***
// power fail and restart sequencer with cycle timer, watchdog and axi4-lite registers
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "pfrs_defs.svh"

module pfrs_sequencer #(
  parameter int N_OUT = 16,
  parameter int N_EXT = 4,
  parameter int N_CHART = 8,
  parameter int MS_CYCLES = `PFRS_MS_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address, data and response
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power supervision
  input wire logic power_fail,
  input wire logic save_done,
  // front panel, monitoring and application inputs
  input wire logic panel_edit,
  input wire logic pc_monitor,
  input wire logic [5:0] active_displays,
  input wire logic [N_OUT-1:0] app_outputs,
  input wire logic app_cycle_done,
  input wire logic [N_OUT-1:0] latch_inputs,
  input wire logic [N_CHART-1:0] chart_tokens,
  // extension links
  input wire logic [N_EXT-1:0] ext_ok,
  // outputs toward application and plant
  output logic [N_OUT-1:0] relay_out,
  output logic cycle_tick,
  output logic analog_sample,
  output logic app_run,
  output logic keys_enable,
  output logic display_on,
  output logic backlight_on,
  output logic ext_link_on,
  output logic rtc_battery_keep,
  output logic save_req,
  output logic restart_init,
  output logic [N_OUT-1:0] init_clear_mask,
  output logic [N_CHART-1:0] chart_restore,
  output logic watchdog_alarm,
  output logic watchdog_error
);

  pfrs_pkg::pfrs_state_t state_reg;
  pfrs_pkg::pfrs_state_t state_next;
  logic [31:0] ctrl_reg;
  logic [7:0] cycle_ms_reg;
  logic [N_OUT-1:0] latch_reg;
  logic [N_CHART-1:0] chart_reinit_reg;
  logic [N_OUT-1:0] saved_reg;
  logic [31:0] ms_cnt_reg;
  logic ms_tick;
  logic [7:0] cyc_cnt_reg;
  logic analog_phase_reg;
  logic busy_reg;
  logic overrun_reg;
  logic wd_quiet;
  logic all_ext_ok;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic [31:0] rd_val;

  assign all_ext_ok = &ext_ok;
  // watchdog quiet while editing from panel or monitoring from a pc
  assign wd_quiet = panel_edit | pc_monitor;

  // state advance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= pfrs_pkg::PFRS_ST_STOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // sequence of outage and restart
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pfrs_pkg::PFRS_ST_STOP: begin
        if (ctrl_reg[`PFRS_CTRL_RUN] && !power_fail) begin
          state_next = pfrs_pkg::PFRS_ST_RUN;
        end
      end
      pfrs_pkg::PFRS_ST_RUN: begin
        if (power_fail) begin
          state_next = pfrs_pkg::PFRS_ST_HOLD;
        end else if (!ctrl_reg[`PFRS_CTRL_RUN]) begin
          state_next = pfrs_pkg::PFRS_ST_STOP;
        end
      end
      pfrs_pkg::PFRS_ST_HOLD: begin
        if (save_done) begin
          state_next = pfrs_pkg::PFRS_ST_OFF;
        end
      end
      pfrs_pkg::PFRS_ST_OFF: begin
        if (!power_fail) begin
          state_next = pfrs_pkg::PFRS_ST_CHECK;
        end
      end
      pfrs_pkg::PFRS_ST_CHECK: begin
        if (power_fail) begin
          state_next = pfrs_pkg::PFRS_ST_OFF;
        end else if (all_ext_ok) begin
          state_next = pfrs_pkg::PFRS_ST_RESTORE;
        end
      end
      pfrs_pkg::PFRS_ST_RESTORE: begin
        state_next = pfrs_pkg::PFRS_ST_INIT;
      end
      pfrs_pkg::PFRS_ST_INIT: begin
        state_next = power_fail ? pfrs_pkg::PFRS_ST_HOLD : pfrs_pkg::PFRS_ST_RUN;
      end
      default: begin
        state_next = pfrs_pkg::PFRS_ST_STOP;
      end
    endcase
  end

  // millisecond divider, held at zero during outage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else if (!app_run || ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
    end
  end
  assign ms_tick = app_run && (ms_cnt_reg == 32'(MS_CYCLES - 1));

  // execution cycle counter paces sampling and the busy and overrun check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_cnt_reg <= 8'h00;
      cycle_tick <= 1'b0;
    end else begin
      cycle_tick <= 1'b0;
      if (!app_run) begin
        cyc_cnt_reg <= 8'h00;
      end else if (ms_tick) begin
        if (cyc_cnt_reg + 8'h01 >= cycle_ms_reg) begin
          cyc_cnt_reg <= 8'h00;
          cycle_tick <= 1'b1;
        end else begin
          cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
        end
      end
    end
  end

  // analog acquisition every second tick on ac units with a cycle below 20 ms, every tick otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_phase_reg <= 1'b0;
      analog_sample <= 1'b0;
    end else begin
      analog_sample <= 1'b0;
      if (cycle_tick) begin
        if (ctrl_reg[`PFRS_CTRL_AC_SUPPLY] &&
            cycle_ms_reg < 8'(`PFRS_ANALOG_MS)) begin
          analog_phase_reg <= ~analog_phase_reg;
          analog_sample <= analog_phase_reg;
        end else begin
          analog_sample <= 1'b1;
        end
      end
    end
  end

  // application busy flag, cleared when the cycle's work is finished
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      overrun_reg <= 1'b0;
      if (!app_run) begin
        busy_reg <= 1'b0;
      end else if (cycle_tick) begin
        overrun_reg <= busy_reg;
        busy_reg <= 1'b1;
      end else if (app_cycle_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // watchdog action, off after reset until software enables it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_alarm <= 1'b0;
      watchdog_error <= 1'b0;
    end else begin
      if (overrun_reg && ctrl_reg[`PFRS_CTRL_WDG_EN] && !wd_quiet) begin
        watchdog_alarm <= watchdog_alarm | !ctrl_reg[`PFRS_CTRL_WDG_ERR];
        watchdog_error <= watchdog_error | ctrl_reg[`PFRS_CTRL_WDG_ERR];
      end else if (do_write && aw_addr_reg == `PFRS_OFF_STATUS && w_strb_reg[0]) begin
        watchdog_alarm <= watchdog_alarm & ~w_data_reg[0];
        watchdog_error <= watchdog_error & ~w_data_reg[1];
      end
    end
  end

  // output capture and relay drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saved_reg <= '0;
      relay_out <= '0;
    end else begin
      case (state_reg)
        pfrs_pkg::PFRS_ST_RUN: begin
          if (!power_fail) begin
            relay_out <= app_outputs;
            saved_reg <= app_outputs;
          end
        end
        pfrs_pkg::PFRS_ST_INIT: begin
          relay_out <= app_outputs;
        end
        pfrs_pkg::PFRS_ST_HOLD: begin
          if (save_done) relay_out <= '0;
        end
        pfrs_pkg::PFRS_ST_RESTORE: begin
          relay_out <= saved_reg;
        end
        pfrs_pkg::PFRS_ST_STOP: begin
          relay_out <= '0;
        end
        default: begin
          relay_out <= '0;
        end
      endcase
    end
  end

  // per-block restart masks: latched outputs keep their outage value
  genvar gi;
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_latch
      assign init_clear_mask[gi] = restart_init & ~latch_reg[gi];
    end
    for (gi = 0; gi < N_CHART; gi++) begin : g_chart
      assign chart_restore[gi] = restart_init & chart_tokens[gi] & chart_reinit_reg[gi];
    end
  endgenerate

  // status outputs decoded from the sequence
  assign app_run = (state_reg == pfrs_pkg::PFRS_ST_RUN) && !power_fail;
  assign keys_enable = app_run || (state_reg == pfrs_pkg::PFRS_ST_STOP && !power_fail);
  assign save_req = (state_reg == pfrs_pkg::PFRS_ST_HOLD);
  assign restart_init = (state_reg == pfrs_pkg::PFRS_ST_INIT);
  assign display_on = !(state_reg inside {pfrs_pkg::PFRS_ST_HOLD, pfrs_pkg::PFRS_ST_OFF});
  assign backlight_on = display_on;
  assign ext_link_on = !(state_reg inside {pfrs_pkg::PFRS_ST_HOLD, pfrs_pkg::PFRS_ST_OFF});
  assign rtc_battery_keep = 1'b1;

  // axi4-lite write channel capture in either order
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'b00;

  // software register writes, byte lane 0 and 1 wide enough here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `PFRS_CTRL_RESET;
      cycle_ms_reg <= `PFRS_CYCLE_MS_RESET;
      latch_reg <= '0;
      chart_reinit_reg <= '0;
    end else if (do_write) begin
      case (aw_addr_reg)
        `PFRS_OFF_CTRL: begin
          if (w_strb_reg[0]) ctrl_reg[7:0] <= w_data_reg[7:0];
        end
        `PFRS_OFF_CYCLE: begin
          if (w_strb_reg[0] && w_data_reg[7:0] != 8'h00) cycle_ms_reg <= w_data_reg[7:0];
        end
        `PFRS_OFF_LATCH: begin
          latch_reg <= w_data_reg[N_OUT-1:0];
        end
        `PFRS_OFF_CHART: begin
          chart_reinit_reg <= w_data_reg[N_CHART-1:0];
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `PFRS_OFF_CTRL: rd_val = ctrl_reg;
      `PFRS_OFF_STATUS: rd_val = {17'h0_0000, state_reg, 1'b0, pc_monitor, panel_edit,
                                  all_ext_ok, power_fail, busy_reg, watchdog_error,
                                  watchdog_alarm};
      `PFRS_OFF_CYCLE: rd_val = {24'h00_0000, cycle_ms_reg};
      `PFRS_OFF_LATCH: rd_val = 32'(latch_reg);
      `PFRS_OFF_CHART: rd_val = 32'(chart_reinit_reg);
      `PFRS_OFF_OUTS: rd_val = 32'(relay_out);
      `PFRS_OFF_SAVED: rd_val = 32'(saved_reg);
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // axi4-lite read channel, one read at a time
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_rresp = 2'b00;

endmodule // pfrs_sequencer

// *** tb/pfrs_ext_model.sv ***
// model of the io and fieldbus extensions behind the sequencer
`timescale 1ns/1ns
module pfrs_ext_model #(
  parameter int N_EXT = 4,
  parameter int HOLD_CYC = 800,
  parameter logic [7:0] LOSS_CODE = 8'h5A
) (
  // clock, reset and base unit state
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on,
  input wire logic ext_link_on,
  input wire logic [15:0] relay_out,
  input wire logic [15:0] wake_cyc,
  // extension side
  output logic [N_EXT-1:0] ext_ok,
  output logic [15:0] io_out,
  output logic fb_tx,
  output logic [7:0] fb_status
);
  int up_cnt;
  int down_cnt;
  // time since supply returned and since the link dropped
  always_ff @(posedge aclk) begin
    up_cnt <= (!aresetn || !power_on) ? 0 : up_cnt + 1;
    down_cnt <= (!aresetn || ext_link_on) ? 0 : down_cnt + 1;
  end
  // each extension wakes after its own delay, so answers come soon and late
  always_comb begin
    for (int i = 0; i < N_EXT; i++) begin
      ext_ok[i] = power_on && (up_cnt >= int'(wake_cyc) * (i + 1));
    end
  end
  // outputs keep their value first, then switch off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_out <= 16'h0000;
    end else if (ext_link_on) begin
      io_out <= relay_out;
    end else if (down_cnt == 4) begin
      io_out <= 16'h0000;
    end
  end
  // fieldbus goes on sending, then flags the lost link
  assign fb_tx = ext_link_on || (down_cnt < HOLD_CYC);
  always_ff @(posedge aclk) begin
    if (!aresetn || ext_link_on) begin
      fb_status <= 8'h00;
    end else if (down_cnt == HOLD_CYC) begin
      fb_status <= LOSS_CODE;
    end
  end
endmodule // pfrs_ext_model

// *** tb/pfrs_sequencer_chk.sv ***
// checker of the outage, restart and watchdog behaviour at the sequencer ports
`timescale 1ns/1ns
module pfrs_sequencer_chk #(
  parameter int N_OUT = 16,
  parameter int N_EXT = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched ports
  input wire logic power_fail,
  input wire logic save_done,
  input wire logic panel_edit,
  input wire logic pc_monitor,
  input wire logic [N_EXT-1:0] ext_ok,
  input wire logic [N_OUT-1:0] relay_out,
  input wire logic cycle_tick,
  input wire logic app_run,
  input wire logic keys_enable,
  input wire logic display_on,
  input wire logic backlight_on,
  input wire logic ext_link_on,
  input wire logic save_req,
  input wire logic restart_init,
  input wire logic rtc_battery_keep,
  input wire logic watchdog_alarm,
  input wire logic watchdog_error
);
  // one clock domain for all properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_stop; power_fail |-> !app_run && !keys_enable; endproperty
  a_stop: assert property (p_stop)
    else $error("execution went on after outage");
  property p_hold; save_req && !save_done |=> $stable(relay_out); endproperty
  a_hold: assert property (p_hold)
    else $error("outputs moved while saving");
  property p_off;
    save_req && save_done |=> relay_out == '0 && !display_on && !backlight_on && !ext_link_on;
  endproperty
  a_off: assert property (p_off)
    else $error("outputs not off after saving");
  property p_rtc; rtc_battery_keep; endproperty
  a_rtc: assert property (p_rtc)
    else $error("clock battery hold dropped");
  property p_ext; restart_init |-> $past(&ext_ok, 2); endproperty
  a_ext: assert property (p_ext)
    else $error("restart without all extensions ok");
  property p_init; restart_init |=> app_run && !restart_init; endproperty
  a_init: assert property (p_init)
    else $error("init not followed by run");
  property p_tick; cycle_tick |=> !cycle_tick; endproperty
  a_tick: assert property (p_tick)
    else $error("cycle tick longer than one clock");
  property p_quiet;
    (panel_edit || pc_monitor) && $past(panel_edit || pc_monitor)
      && !watchdog_alarm && !watchdog_error |=> !watchdog_alarm && !watchdog_error;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("watchdog acted while silenced");
  property p_wdrst; $rose(aresetn) |-> !watchdog_alarm && !watchdog_error; endproperty
  a_wdrst: assert property (p_wdrst)
    else $error("watchdog active after reset");
endmodule // pfrs_sequencer_chk

bind pfrs_sequencer pfrs_sequencer_chk #(.N_OUT(N_OUT), .N_EXT(N_EXT)) u_pfrs_sequencer_chk (
  .aclk, .aresetn, .power_fail, .save_done, .panel_edit, .pc_monitor, .ext_ok, .relay_out,
  .cycle_tick, .app_run, .keys_enable, .display_on, .backlight_on, .ext_link_on, .save_req,
  .restart_init, .rtc_battery_keep, .watchdog_alarm, .watchdog_error
);

// *** tb/power_fail_restart_sequencer_tb_top.sv ***
// testbench of the power fail restart sequencer
`timescale 1ns/1ns
`include "pfrs_defs.svh"
module power_fail_restart_sequencer_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic power_fail = 1'h0, save_done = 1'h0, panel_edit = 1'h0, pc_monitor = 1'h0;
  logic app_cycle_done = 1'h1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [5:0] active_displays = 6'h20;
  logic [15:0] latch_inputs = 16'h00FF, wake_cyc = 16'h0028, io_out;
  logic fb_tx;
  logic [7:0] fb_status;
  logic [15:0] app_outputs = 16'h0000, relay_out, init_clear_mask;
  logic [7:0] chart_tokens = 8'hFF, chart_restore;
  logic [3:0] ext_ok;
  logic cycle_tick, analog_sample, app_run, keys_enable, display_on, backlight_on;
  logic ext_link_on, rtc_battery_keep, save_req, restart_init, watchdog_alarm, watchdog_error;
  int fails = 0, comparisons = 0;
  // clock
  always #5 aclk = ~aclk;
  // block under test and its extensions
  pfrs_sequencer #(.N_OUT(16), .N_EXT(4), .N_CHART(8), .MS_CYCLES(10)) u_pfrs_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .power_fail, .save_done, .panel_edit, .pc_monitor,
    .active_displays, .app_outputs, .app_cycle_done, .latch_inputs,
    .chart_tokens, .ext_ok, .relay_out, .cycle_tick, .analog_sample, .app_run, .keys_enable,
    .display_on, .backlight_on, .ext_link_on, .rtc_battery_keep, .save_req, .restart_init,
    .init_clear_mask, .chart_restore, .watchdog_alarm, .watchdog_error);
  pfrs_ext_model #(.N_EXT(4), .HOLD_CYC(800)) u_pfrs_ext_model (.aclk, .aresetn,
    .power_on(!power_fail), .ext_link_on, .relay_out, .wake_cyc, .ext_ok,
    .io_out, .fb_tx, .fb_status);
  // compare and count
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bus write: address and data offered together, each dropped when taken
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b = 1'h0;
    // waits for the answer however long it takes; the hang guard ends a stuck run
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
    end
  endtask
  // bus read into rdat and rrsp
  task rd(input logic [11:0] a);
    logic ar, r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    r = 1'h0;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (r) s_axi_rready <= 1'h0;
    end
  endtask
  // count analog samples over k cycle ticks
  task ticks(input int k, output int s);
    int t;
    t = 0;
    s = 0;
    while (t < k) begin
      @(negedge aclk);
      t += int'(cycle_tick);
      s += int'(analog_sample);
    end
    // the sample of the last tick follows it by one clock
    @(negedge aclk);
    s += int'(analog_sample);
  endtask
  task t_regs;
    rd(`PFRS_OFF_CTRL);
    chk("ctrl", rdat, 32'h0);
    wr(`PFRS_OFF_CYCLE, 32'h0);
    rd(`PFRS_OFF_CYCLE);
    chk("cycle", rdat, 32'h0000000A);
    s_axi_wstrb <= 4'hE;
    wr(`PFRS_OFF_CYCLE, 32'h00000005);
    rd(`PFRS_OFF_CYCLE);
    chk("cycle lane", rdat, 32'h0000000A);
    s_axi_wstrb <= 4'hF;
    wr(`PFRS_OFF_LATCH, 32'h000000FF);
    rd(`PFRS_OFF_LATCH);
    chk("latch", rdat, 32'h000000FF);
    wr(`PFRS_OFF_CHART, 32'h0000000F);
    rd(12'hFFC);
    chk("unmapped resp", rrsp, 32'h0);
  endtask
  task t_analog;
    int s;
    wr(`PFRS_OFF_CTRL, 32'h00000011);
    ticks(20, s);
    chk("samples 10ms", s, 32'h0000000A);
    wr(`PFRS_OFF_CYCLE, 32'h00000014);
    ticks(20, s);
    chk("samples 20ms", s, 32'h00000014);
    wr(`PFRS_OFF_CYCLE, 32'h0000000A);
  endtask
  task t_wdg;
    app_cycle_done <= 1'h0;
    wr(`PFRS_OFF_CTRL, 32'h00000003);
    repeat (300) @(negedge aclk);
    chk("alarm", watchdog_alarm, 1'h1);
    rd(`PFRS_OFF_STATUS);
    chk("status flags", rdat[1:0], 2'h1);
    pc_monitor <= 1'h1;
    wr(`PFRS_OFF_STATUS, 32'h00000003);
    repeat (300) @(negedge aclk);
    chk("alarm monitor", watchdog_alarm, 1'h0);
    @(posedge aclk);
    pc_monitor <= 1'h0;
    panel_edit <= 1'h1;
    repeat (300) @(negedge aclk);
    chk("alarm edit", watchdog_alarm, 1'h0);
    @(posedge aclk);
    panel_edit <= 1'h0;
    wr(`PFRS_OFF_CTRL, 32'h00000007);
    repeat (300) @(negedge aclk);
    chk("error", watchdog_error, 1'h1);
    app_cycle_done <= 1'h1;
    wr(`PFRS_OFF_STATUS, 32'h00000003);
  endtask
  task t_outage;
    int n;
    wr(`PFRS_OFF_CTRL, 32'h00000001);
    app_outputs <= 16'hA5C3;
    repeat (250) @(negedge aclk);
    chk("relay run", relay_out, 16'hA5C3);
    @(posedge aclk);
    power_fail <= 1'h1;
    app_outputs <= 16'h1234;
    repeat (3) @(negedge aclk);
    chk("run", {app_run, keys_enable, save_req}, 3'h1);
    chk("io retain", io_out, 16'hA5C3);
    repeat (20) @(negedge aclk);
    chk("relay hold", relay_out, 16'hA5C3);
    chk("io off", io_out, 16'h0000);
    chk("fb tx", fb_tx, 1'h1);
    @(posedge aclk);
    save_done <= 1'h1;
    @(posedge aclk);
    save_done <= 1'h0;
    repeat (3) @(negedge aclk);
    chk("off", {relay_out, display_on, backlight_on, ext_link_on}, 19'h0);
    // stay down past the fieldbus hold so the lost-link code shows
    repeat (800) @(negedge aclk);
    chk("fb lost", {fb_tx, fb_status}, 9'h05A);
    @(posedge aclk);
    power_fail <= 1'h0;
    for (n = 0; n < 1000 && ext_ok !== 4'h7; n++) @(negedge aclk);
    chk("relay check", {relay_out, restart_init}, 17'h0);
    for (n = 0; n < 1000 && restart_init !== 1'h1; n++) @(negedge aclk);
    chk("relay restored", relay_out, 16'hA5C3);
    chk("clear mask", init_clear_mask, 16'hFF00);
    chk("chart", chart_restore, 8'h0F);
    @(negedge aclk);
    chk("run again", app_run, 1'h1);
  endtask
  // verdict and end of run
  task print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_analog;
    t_wdg;
    t_outage;
    print_verdict;
  end
  // hang guard
  initial begin
    #500000;
    fails++;
    print_verdict;
  end
endmodule // power_fail_restart_sequencer_tb_top
